//--- core/pump_and_tuning_config_regs.sv
// Behaviour
// R01: Sink gain code bits 6..0 sets sink current, 20 uA per step, reset 100.
// R02: Source gain code bits 13..7 sets source current, 20 uA per step, reset 100.
// R03: Offset magnitude bits 20..14 sets offset current, 5 uA per step, reset zero.
// R04: Software keeps upward offset enable bit 21 at 0; resets to 0.
// R05: Software sets downward offset bit 22 only in fractional mode; resets to 1.
// R06: Span code bits 2..0 selects 1,2,4,8,32,64,128,256 reference cycles; reset 5.
// R07: Bit 10 forces band curve from 05h; bit 11 bypasses automatic tuning.
// R08: Bit 12 set stops writes to 05h from starting an oscillator-side transfer.
// R09: Bits 14..13 divide reference by 1,4,16,32 for calibration clock; reset 1.
// R10: All fields, reserved included, hold the last written value and read back.
`timescale 1ns/1ps
module pump_and_tuning_config_regs (
  // ----------------------------------------------------------------
  // Clock and control
  // ----------------------------------------------------------------
  input  wire logic                       clock,
  input  wire logic                       reset,
  input  wire logic                       enable,

  // ----------------------------------------------------------------
  // Serial programming port
  // ----------------------------------------------------------------
  input  wire logic                       select_n,
  input  wire logic                       serial_clock,
  input  wire logic                       serial_in,
  output logic                            serial_out,
  output logic                            serial_out_oe,

  // ----------------------------------------------------------------
  // Pump settings
  // ----------------------------------------------------------------
  output logic [pump_cal_pkg::GAIN_W-1:0] pump_sink_gain,
  output logic [pump_cal_pkg::GAIN_W-1:0] pump_source_gain,
  output logic [pump_cal_pkg::GAIN_W-1:0] offset_magnitude,
  output logic                            offset_source_enable,
  output logic                            offset_sink_enable,
  output logic [11:0]                     sink_current_ua,
  output logic [11:0]                     source_current_ua,
  output logic [9:0]                      offset_current_ua,

  // ----------------------------------------------------------------
  // Calibration settings
  // ----------------------------------------------------------------
  output logic [8:0]                      measurement_span,
  output logic                            force_band_curve,
  output logic                            skip_oscillator_tuning,
  output logic                            write_transfer_start,
  output logic                            calibration_tick
);

  import pump_cal_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    // Synchronisers, oldest stage highest
    logic [2:0]            sel_sync;
    logic [2:0]            sck_sync;
    logic [1:0]            sdi_sync;
    // Frame assembly
    logic [4:0]            bit_count;
    logic                  overrun;
    logic [FRAME_BITS-1:0] shift;
    logic [DATA_W-1:0]     out_shift;
    logic                  sdo;
    logic                  sdo_oe;
    // Stored registers
    logic [DATA_W-1:0]     pump;
    logic [DATA_W-1:0]     cal;
    logic                  start;
    // Decoded copies
    logic [11:0]           sink_ua;
    logic [11:0]           source_ua;
    logic [9:0]            offset_ua;
    logic [8:0]            span;
  } regs_t;

  regs_t                 st_reg;
  regs_t                 st_next;
  logic                  sck_rise;
  logic                  sel_rise;
  logic                  selected;
  logic [FRAME_BITS-1:0] shifted;
  logic [DATA_W-1:0]     read_word;
  logic                  head_done;
  logic                  write_ok;

  // ----------------------------------------------------------------
  // Synchronisers and frame status
  // ----------------------------------------------------------------
  // Only stage 1 and the delayed copy feed edge detection
  assign sck_rise = st_reg.sck_sync[1] & ~st_reg.sck_sync[2];
  assign sel_rise = st_reg.sel_sync[1] & ~st_reg.sel_sync[2];
  assign selected = ~st_reg.sel_sync[1];
  assign shifted  = {st_reg.shift[FRAME_BITS-2:0], st_reg.sdi_sync[1]};
  assign head_done = (st_reg.bit_count == HEAD_COUNT - 5'h01);
  // Exact length, no overrun, write direction
  assign write_ok  = (st_reg.bit_count == FRAME_COUNT) & ~st_reg.overrun
                   & ~st_reg.shift[FRAME_BITS-1];

  // ----------------------------------------------------------------
  // Readback select
  // ----------------------------------------------------------------
  // Unmapped addresses read as zero
  always_comb begin
    case (shifted[ADDR_W-1:0])
      PUMP_ADDR: read_word = st_reg.pump;
      CAL_ADDR:  read_word = st_reg.cal;
      default:   read_word = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next          = st_reg;
    st_next.sel_sync = {st_reg.sel_sync[1:0], select_n};
    st_next.sck_sync = {st_reg.sck_sync[1:0], serial_clock};
    st_next.sdi_sync = {st_reg.sdi_sync[0], serial_in};
    st_next.start    = 1'b0;

    // ----------------------------------------------------------------
    // Serial shift: rw bit, address, then data, MSB first
    // ----------------------------------------------------------------
    if (selected && sck_rise) begin
      st_next.shift = shifted;
      if (st_reg.bit_count != FRAME_COUNT) begin
        st_next.bit_count = st_reg.bit_count + 5'h01;
      end else begin
        // Count saturates, so an extra bit is remembered here
        st_next.overrun = 1'b1;
      end
      // First data bit goes out as soon as the header is in
      if (head_done && shifted[ADDR_W]) begin
        st_next.out_shift = {read_word[DATA_W-2:0], 1'b0};
        st_next.sdo       = read_word[DATA_W-1];
        st_next.sdo_oe    = 1'b1;
      end else if (st_reg.sdo_oe) begin
        st_next.out_shift = {st_reg.out_shift[DATA_W-2:0], 1'b0};
        st_next.sdo       = st_reg.out_shift[DATA_W-1];
      end
    end

    // ----------------------------------------------------------------
    // Commit on deselect; partial or overlong frames are dropped
    // ----------------------------------------------------------------
    if (sel_rise) begin
      // Driver drops before the next frame can begin
      st_next.bit_count = '0;
      st_next.overrun   = 1'b0;
      st_next.sdo_oe    = 1'b0;
      st_next.sdo       = 1'b0;
      if (write_ok) begin
        // Band word is not stored here, only its trigger
        case (st_reg.shift[FRAME_BITS-2 -: ADDR_W])
          PUMP_ADDR: st_next.pump = st_reg.shift[DATA_W-1:0]; // R10
          CAL_ADDR:  st_next.cal  = st_reg.shift[DATA_W-1:0]; // R10
          BAND_ADDR: st_next.start = ~st_reg.cal[SUPPRESS_BIT]; // R08
          default:   st_next.start = 1'b0;
        endcase
      end
    end

    // ----------------------------------------------------------------
    // Decoded settings, registered so outputs come from flops
    // ----------------------------------------------------------------
    st_next.sink_ua   = 12'(st_reg.pump[SINK_LSB +: GAIN_W]) * GAIN_STEP_UA;     // R01
    st_next.source_ua = 12'(st_reg.pump[SOURCE_LSB +: GAIN_W]) * GAIN_STEP_UA;   // R02
    st_next.offset_ua = 10'(st_reg.pump[OFFSET_LSB +: GAIN_W]) * OFFSET_STEP_UA; // R03
    st_next.span      = SPAN_TABLE[st_reg.cal[SPAN_LSB +: SPAN_W]];              // R06
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_reg           <= '0;
      st_reg.sel_sync  <= '1;
      st_reg.pump      <= PUMP_RESET; // R01 R02 R03 R04 R05
      st_reg.cal       <= CAL_RESET;  // R06 R07 R08 R09
      // Decoded copies read zero until the first enabled edge
      st_reg.sink_ua   <= '0;
      st_reg.source_ua <= '0;
      st_reg.span      <= '0;
    end else if (enable) begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Calibration clock divider
  // ----------------------------------------------------------------
  // A low enable also freezes a tick that stands high
  calib_clock_divider divider (
    .clock       (clock),
    .reset       (reset),
    .enable      (enable),
    .divider_sel (st_reg.cal[DIVSEL_LSB +: DIVSEL_W]), // R09
    .tick        (calibration_tick)
  );

  // ----------------------------------------------------------------
  // Setting outputs
  // ----------------------------------------------------------------
  // Slices of the register flops, no logic between
  assign pump_sink_gain         = st_reg.pump[SINK_LSB +: GAIN_W];
  assign pump_source_gain       = st_reg.pump[SOURCE_LSB +: GAIN_W];
  assign offset_magnitude       = st_reg.pump[OFFSET_LSB +: GAIN_W];
  assign offset_source_enable   = st_reg.pump[OFFSET_UP_BIT];
  assign offset_sink_enable     = st_reg.pump[OFFSET_DN_BIT];
  assign force_band_curve       = st_reg.cal[FORCE_BIT]; // R07
  assign skip_oscillator_tuning = st_reg.cal[SKIP_BIT];  // R07
  assign sink_current_ua        = st_reg.sink_ua;
  assign source_current_ua      = st_reg.source_ua;
  assign offset_current_ua      = st_reg.offset_ua;
  assign measurement_span       = st_reg.span;
  assign write_transfer_start   = st_reg.start;

  // ----------------------------------------------------------------
  // Serial port outputs
  // ----------------------------------------------------------------
  assign serial_out             = st_reg.sdo;
  assign serial_out_oe          = st_reg.sdo_oe;

endmodule // pump_and_tuning_config_regs

//--- core/pump_cal_pkg.sv
package pump_cal_pkg;

  // ----------------------------------------------------------------
  // Serial frame layout
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 6;
  localparam int          DATA_W       = 24;
  localparam int          HEAD_BITS    = 1 + ADDR_W;
  localparam int          FRAME_BITS   = HEAD_BITS + DATA_W;
  localparam logic [4:0]  HEAD_COUNT   = 5'h07;
  localparam logic [4:0]  FRAME_COUNT  = 5'h1F;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] BAND_ADDR = 6'h05;
  localparam logic [ADDR_W-1:0] PUMP_ADDR = 6'h09;
  localparam logic [ADDR_W-1:0] CAL_ADDR  = 6'h0A;
  localparam logic [DATA_W-1:0] PUMP_RESET = 24'h403264;
  localparam logic [DATA_W-1:0] CAL_RESET  = 24'h002205;

  // ----------------------------------------------------------------
  // Pump register fields
  // ----------------------------------------------------------------
  localparam int GAIN_W        = 7;
  localparam int SINK_LSB      = 0;
  localparam int SOURCE_LSB    = 7;
  localparam int OFFSET_LSB    = 14;
  localparam int OFFSET_UP_BIT = 21;
  localparam int OFFSET_DN_BIT = 22;
  localparam logic [11:0] GAIN_STEP_UA   = 12'h014;
  localparam logic [9:0]  OFFSET_STEP_UA = 10'h005;

  // ----------------------------------------------------------------
  // Calibration register fields
  // ----------------------------------------------------------------
  localparam int SPAN_LSB     = 0;
  localparam int SPAN_W       = 3;
  localparam int FORCE_BIT    = 10;
  localparam int SKIP_BIT     = 11;
  localparam int SUPPRESS_BIT = 12;
  localparam int DIVSEL_LSB   = 13;
  localparam int DIVSEL_W     = 2;

  // Span in reference-divider cycles, indexed by code
  localparam logic [7:0][8:0] SPAN_TABLE = {9'h100, 9'h080, 9'h040, 9'h020,
                                            9'h008, 9'h004, 9'h002, 9'h001};
  // Reference divide ratio, indexed by selector code
  localparam logic [3:0][5:0] DIV_TABLE  = {6'h20, 6'h10, 6'h04, 6'h01};

endpackage

//--- core/calib_clock_divider.sv
`timescale 1ns/1ps
module calib_clock_divider (
  input  wire logic                              clock,
  input  wire logic                              reset,
  input  wire logic                              enable,
  input  wire logic [pump_cal_pkg::DIVSEL_W-1:0] divider_sel,
  output logic                                   tick
);

  import pump_cal_pkg::*;

  typedef struct packed {
    logic [5:0] count;
    logic       tick;
  } div_state_t;

  div_state_t st_reg;
  div_state_t st_next;
  logic [5:0] terminal;

  assign terminal = DIV_TABLE[divider_sel] - 6'h01;
  assign tick     = st_reg.tick;

  always_comb begin
    st_next = st_reg;
    // Selector change mid-count just lands on the new terminal or wraps
    if (st_reg.count >= terminal) begin
      st_next.count = '0;
      st_next.tick  = 1'b1;
    end else begin
      st_next.count = st_reg.count + 6'h01;
      st_next.tick  = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else if (enable) begin
      st_reg <= st_next;
    end
  end

endmodule // calib_clock_divider

//--- bench/pump_cal_checker.sv
`timescale 1ns/1ps
module pump_cal_checker (
  input wire logic                           clock,
  input wire logic                           reset,
  input wire logic                           enable,
  input wire logic                           select_n,
  input wire logic                           serial_out,
  input wire logic                           serial_out_oe,
  input wire logic [pump_cal_pkg::GAIN_W-1:0] pump_sink_gain,
  input wire logic [pump_cal_pkg::GAIN_W-1:0] pump_source_gain,
  input wire logic [pump_cal_pkg::GAIN_W-1:0] offset_magnitude,
  input wire logic [11:0]                    sink_current_ua,
  input wire logic [11:0]                    source_current_ua,
  input wire logic [9:0]                     offset_current_ua,
  input wire logic [8:0]                     measurement_span,
  input wire logic                           write_transfer_start
);
  import pump_cal_pkg::*;
  // --------------------------------
  // Port relations
  // --------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_sink_current: assert property (!$past(reset) && $past(enable) |->
    sink_current_ua == $past(pump_sink_gain) * GAIN_STEP_UA) else $error("sink current wrong");
  a_source_current: assert property (!$past(reset) && $past(enable) |->
    source_current_ua == $past(pump_source_gain) * GAIN_STEP_UA) else $error("source wrong");
  a_offset_current: assert property (!$past(reset) && $past(enable) |->
    offset_current_ua == $past(offset_magnitude) * OFFSET_STEP_UA) else $error("offset wrong");
  a_span_legal: assert property (!$past(reset) |-> measurement_span inside
    {9'h001, 9'h002, 9'h004, 9'h008, 9'h020, 9'h040, 9'h080, 9'h100}) else $error("bad span");
  a_start_single: assert property (write_transfer_start |=> !write_transfer_start)
    else $error("start pulse too long");
  a_start_deselected: assert property (write_transfer_start |-> select_n && $past(select_n, 2))
    else $error("start while selected");
  a_out_quiet: assert property (!serial_out_oe |-> !serial_out) else $error("out not idle");
  a_oe_release: assert property (select_n [*8] |-> !serial_out_oe)
    else $error("oe held after deselect");
  cover property (write_transfer_start);
  cover property ($rose(serial_out_oe));
  cover property (offset_current_ua == 10'h27B);
endmodule // pump_cal_checker

bind pump_and_tuning_config_regs pump_cal_checker chk_u (.clock(clock), .reset(reset),
  .enable(enable), .select_n(select_n), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
  .pump_sink_gain(pump_sink_gain), .pump_source_gain(pump_source_gain),
  .offset_magnitude(offset_magnitude), .sink_current_ua(sink_current_ua),
  .source_current_ua(source_current_ua), .offset_current_ua(offset_current_ua),
  .measurement_span(measurement_span), .write_transfer_start(write_transfer_start));

//--- bench/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  import pump_cal_pkg::*;
  logic              clock, reset, enable, select_n, serial_clock, serial_in;
  logic              serial_out, serial_out_oe, offset_source_enable, offset_sink_enable;
  logic              force_band_curve, skip_oscillator_tuning, write_transfer_start;
  logic              calibration_tick;
  logic [GAIN_W-1:0] pump_sink_gain, pump_source_gain, offset_magnitude;
  logic [11:0]       sink_current_ua, source_current_ua;
  logic [9:0]        offset_current_ua;
  logic [8:0]        measurement_span;
  logic [23:0]       q;
  int                fails = 0, samples_checked = 0, cycles = 0, starts = 0, n;
  int                divs [4] = '{1, 4, 16, 32};
  pump_and_tuning_config_regs dut_u (.clock(clock), .reset(reset), .enable(enable),
    .select_n(select_n), .serial_clock(serial_clock), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe), .pump_sink_gain(pump_sink_gain),
    .pump_source_gain(pump_source_gain), .offset_magnitude(offset_magnitude),
    .offset_source_enable(offset_source_enable), .offset_sink_enable(offset_sink_enable),
    .sink_current_ua(sink_current_ua), .source_current_ua(source_current_ua),
    .offset_current_ua(offset_current_ua), .measurement_span(measurement_span),
    .force_band_curve(force_band_curve), .skip_oscillator_tuning(skip_oscillator_tuning),
    .write_transfer_start(write_transfer_start), .calibration_tick(calibration_tick));
  // --------------------------------
  // Serial access and checks
  // --------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (write_transfer_start === 1'b1) starts <= starts + 1;
    if (cycles == 30000) begin
      fails++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checked=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Five clocks a phase keeps clear of the synchroniser floor
  task automatic frame(input logic rw, input logic [5:0] a, input logic [23:0] d, input int nb);
    logic [30:0] w;
    w = {rw, a, d};
    q = 24'h000000;
    select_n <= 1'b0;
    repeat (5) @(posedge clock);
    for (int i = 0; i < nb; i++) begin
      serial_in <= w[30 - (i % 31)];
      repeat (5) @(posedge clock);
      if (i >= 7) q = {q[22:0], serial_out};
      serial_clock <= 1'b1;
      repeat (5) @(posedge clock);
      serial_clock <= 1'b0;
    end
    select_n <= 1'b1;
    serial_in <= ~serial_in;
    repeat (10) @(posedge clock);
  endtask
  task automatic ticks();
    n = 0;
    repeat (64) begin
      @(posedge clock);
      if (calibration_tick === 1'b1) n++;
    end
  endtask
  initial begin
    reset <= 1'b1;
    enable <= 1'b1;
    select_n <= 1'b1;
    serial_clock <= 1'b0;
    serial_in <= 1'b0;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    repeat (3) @(posedge clock);
    `CHK({pump_sink_gain, pump_source_gain, offset_magnitude}, 21'h193200)
    `CHK({sink_current_ua, source_current_ua}, 24'h7D07D0)
    `CHK(offset_current_ua, 10'h000)
    `CHK({offset_sink_enable, offset_source_enable}, 2'h2)
    `CHK(measurement_span, 9'h040)
    `CHK({skip_oscillator_tuning, force_band_curve}, 2'h0)
    frame(1'b1, PUMP_ADDR, 24'h000000, 31);
    `CHK(q, PUMP_RESET)
    frame(1'b1, CAL_ADDR, 24'h000000, 31);
    `CHK(q, CAL_RESET)
    frame(1'b0, PUMP_ADDR, 24'hDFFFFF, 31);
    `CHK({sink_current_ua, source_current_ua}, 24'h9EC9EC)
    `CHK(offset_current_ua, 10'h27B)
    `CHK({offset_sink_enable, offset_source_enable}, 2'h2)
    frame(1'b0, PUMP_ADDR, 24'h000000, 30);
    frame(1'b0, PUMP_ADDR, 24'h000000, 32);
    frame(1'b1, PUMP_ADDR, 24'h000000, 31);
    `CHK(q, 24'hDFFFFF)
    frame(1'b1, 6'h0B, 24'h000000, 31);
    `CHK(q, 24'h000000)
    frame(1'b0, PUMP_ADDR, 24'h000000, 31);
    `CHK({offset_sink_enable, offset_source_enable, sink_current_ua}, 14'h0000)
    for (int i = 0; i < 8; i++) begin
      frame(1'b0, CAL_ADDR, {9'h155, i[1:0], 1'b0, i[1:0], 7'h55, i[2:0]}, 31);
      `CHK(measurement_span, 9'((i < 4) ? (1 << i) : (1 << (i + 1))))
      `CHK({skip_oscillator_tuning, force_band_curve}, i[1:0])
      frame(1'b1, CAL_ADDR, 24'h000000, 31);
      `CHK(q, {9'h155, i[1:0], 1'b0, i[1:0], 7'h55, i[2:0]})
      repeat (40) @(posedge clock);
      ticks();
      `CHK(n, 64 / divs[i[1:0]])
    end
    n = starts;
    frame(1'b0, BAND_ADDR, 24'h123456, 31);
    `CHK(starts - n, 1)
    frame(1'b0, CAL_ADDR, 24'h003205, 31);
    n = starts;
    frame(1'b0, BAND_ADDR, 24'h123456, 31);
    `CHK(starts - n, 0)
    enable <= 1'b0;
    @(posedge clock);
    // Frozen tick may stand high, so count changes instead
    q[0] = calibration_tick;
    n = 0;
    repeat (64) begin
      @(posedge clock);
      if (calibration_tick !== q[0]) n++;
    end
    `CHK(n, 0)
    enable <= 1'b1;
    stop_test();
  end
endmodule // testbench
